// ### hdl/dacs_map.svh
// Widths, field positions and timing counts of the dual converter sequencer.
`ifndef DACS_MAP_SVH
`define DACS_MAP_SVH
`define DACS_CLK_PERIOD_NS   100
`define DACS_CONV_CYCLES     20
`define DACS_FRAME_BITS      20
`define DACS_MERGED_CYCLES   40
`define DACS_RESULT_BITS     16
`define DACS_BUSY_DROP_BIT   18
`define DACS_CONVERT_START_MIN_NS   15
`define DACS_CONVERT_START_MIN_CYC  ((`DACS_CONVERT_START_MIN_NS + `DACS_CLK_PERIOD_NS - 1) / `DACS_CLK_PERIOD_NS)
`endif

// ### hdl/dacs_pkg.sv
// Types shared by the dual converter sequencer.
package dacs_pkg;
	typedef logic [15:0] dacs_word_t;
	typedef logic [5:0]  dacs_cnt_t;
	typedef enum logic [2:0] {
		DACS_IDLE  = 3'b001,
		DACS_FRAME = 3'b010,
		DACS_TAIL  = 3'b100
	} dacs_state_t;
endpackage

// ### hdl/dacs_sequencer.sv
// Conversion and serial output sequencer of a dual simultaneous converter.
// Notes on behaviour
// - Each conversion takes no fewer than 20 master clock cycles.
// - A convert_start rise holds both sample stages and starts both converters at once.
// - channel_count_select high alternates pairs after each conversion and ignores channel_pair_select.
// - With channel_count_select low the pair given by channel_pair_select is converted.
// - output_merge_select picks parallel A and B outputs or both results in turn on output A.
// - A frame is pair bit, converter bit, 16 result bits MSB first, two zeros, one bit per clock.
// - Busy rises when conversion begins and falls on the clock that drives the LSB of the last result.
// - Serial outputs are driven only while chip select is low, else high impedance.
// - Merged output takes 40 cycles and a second convert_start inside that time is ignored.
`timescale 1ns/1ps
`include "dacs_map.svh"
module dacs_sequencer (
	// Clock and reset.
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Host strobes.
	input  wire logic                 convert_start,
	input  wire logic                 read_sync,
	input  wire logic                 cs_n,
	// Mode selects.
	input  wire logic                 channel_count_select,
	input  wire logic                 output_merge_select,
	input  wire logic                 channel_pair_select,
	// Converter core.
	input  wire dacs_pkg::dacs_word_t result_a,
	input  wire dacs_pkg::dacs_word_t result_b,
	output logic                      hold,
	output logic                      pair_sel,
	// Serial outputs and busy.
	output logic                      sdata_a,
	output logic                      sdata_a_oe,
	output logic                      sdata_b,
	output logic                      sdata_b_oe,
	output logic                      busy
);
	import dacs_pkg::*;

	dacs_state_t state_r;
	dacs_cnt_t   cnt_r;
	logic        conv_d_r;
	logic        rd_d_r;
	logic        merged_r;
	logic        second_r;
	logic        pair_r;
	logic        load_a;
	logic        load_b;
	logic        shift_en;
	logic        sa_bit;
	logic        sb_bit;
	logic        start;
	logic [1:0]  tag_a;
	logic [1:0]  tag_b;
	logic        pair_nxt;
	logic        pair_tag;
	dacs_cnt_t   busy_len_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			conv_d_r <= 1'b0;
			rd_d_r   <= 1'b0;
		end else begin
			conv_d_r <= convert_start;
			rd_d_r   <= read_sync;
		end
	end

	assign start = convert_start & ~conv_d_r & (state_r == DACS_IDLE);

	// Pair of the conversion being started; the tag is loaded on the start cycle, before pair_r moves.
	assign pair_nxt = channel_count_select ? ~pair_sel : channel_pair_select;
	assign pair_tag = start ? pair_nxt : pair_r;

	// Tags: pair bit then converter bit; pair bit only meaningful in four-channel mode.
	assign tag_a = {channel_count_select & pair_tag, 1'b0};
	assign tag_b = {channel_count_select & pair_tag, output_merge_select};

	// Frame sequencing: first frame, then a second frame of B when merged.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r  <= DACS_IDLE;
			cnt_r    <= 6'h00;
			merged_r <= 1'b0;
			second_r <= 1'b0;
		end else begin
			unique case (state_r)
				DACS_IDLE: begin
					if (start) begin
						state_r  <= DACS_FRAME;
						cnt_r    <= 6'h00;
						merged_r <= output_merge_select;
						second_r <= 1'b0;
					end
				end
				DACS_FRAME: begin
					if (cnt_r == 6'(`DACS_FRAME_BITS - 1)) begin
						cnt_r <= 6'h00;
						if (merged_r && !second_r) begin
							second_r <= 1'b1;
							state_r  <= DACS_TAIL;
						end else begin
							state_r <= DACS_IDLE;
						end
					end else begin
						cnt_r <= cnt_r + 6'h01;
					end
				end
				DACS_TAIL: begin
					if (cnt_r == 6'(`DACS_FRAME_BITS - 1)) begin
						cnt_r   <= 6'h00;
						state_r <= DACS_IDLE;
					end else begin
						cnt_r <= cnt_r + 6'h01;
					end
				end
				default: begin
					state_r <= DACS_IDLE;
				end
			endcase
		end
	end

	// Pair selection latched at each start.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pair_r   <= 1'b0;
			pair_sel <= 1'b0;
		end else if (start) begin
			if (channel_count_select) begin
				pair_r   <= ~pair_sel;
				pair_sel <= ~pair_sel;
			end else begin
				pair_r   <= channel_pair_select;
				pair_sel <= channel_pair_select;
			end
		end
	end

	assign load_a   = start | (state_r == DACS_FRAME && cnt_r == 6'(`DACS_FRAME_BITS - 1) && merged_r);
	assign load_b   = start;
	assign shift_en = (state_r != DACS_IDLE);

	// B frame goes to A when merged
	dacs_shifter u_shift_a (
		.clock    (clock),
		.rst      (rst),
		.load     (load_a),
		.shift    (shift_en),
		.tag_bits (start ? tag_a : tag_b),
		.result   (start ? result_a : result_b),
		.bit_out  (sa_bit)
	);

	dacs_shifter u_shift_b (
		.clock    (clock),
		.rst      (rst),
		.load     (load_b),
		.shift    (shift_en),
		.tag_bits (tag_b),
		.result   (result_b),
		.bit_out  (sb_bit)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sdata_a    <= 1'b0;
			sdata_a_oe <= 1'b0;
			sdata_b    <= 1'b0;
			sdata_b_oe <= 1'b0;
		end else begin
			sdata_a    <= sa_bit;
			sdata_a_oe <= ~cs_n;
			sdata_b    <= sb_bit & ~output_merge_select;
			sdata_b_oe <= ~cs_n & ~merged_r;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			hold <= 1'b0;
		end else begin
			if (start) begin
				busy <= 1'b1;
				hold <= 1'b1;
			end else if (state_r != DACS_IDLE && cnt_r == 6'(`DACS_BUSY_DROP_BIT - 1) &&
				(!merged_r || state_r == DACS_TAIL)) begin
				busy <= 1'b0;
				hold <= 1'b0;
			end
		end
	end

	// Length of the current busy window, read by the busy assertion only.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_len_r <= 6'h00;
		end else if (busy) begin
			busy_len_r <= busy_len_r + 6'h01;
		end else begin
			busy_len_r <= 6'h00;
		end
	end

	// Assertions.
	property p_busy_on_start;
		@(posedge clock) disable iff (rst) start |=> busy;
	endproperty
	a_busy_on_start: assert property (p_busy_on_start) else $error("busy not raised");
	property p_frame_len;
		@(posedge clock) disable iff (rst) (start && !output_merge_select) |=>
			##19 (state_r == DACS_FRAME && cnt_r == 6'(`DACS_FRAME_BITS - 1)) ##1 (state_r == DACS_IDLE);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not 20 cycles");
	property p_cnt_step;
		@(posedge clock) disable iff (rst) (state_r != DACS_IDLE && cnt_r != 6'(`DACS_FRAME_BITS - 1)) |=>
			(state_r == $past(state_r) && cnt_r == $past(cnt_r) + 6'h01);
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("frame count skipped");
	property p_merged_len;
		@(posedge clock) disable iff (rst) (start && output_merge_select) |=> ##39 (state_r == DACS_TAIL) ##1 (state_r == DACS_IDLE);
	endproperty
	a_merged_len: assert property (p_merged_len) else $error("merged not 40 cycles");
	property p_ignore;
		@(posedge clock) disable iff (rst)
			(state_r != DACS_IDLE && cnt_r != 6'(`DACS_FRAME_BITS - 1) && convert_start && !conv_d_r) |=>
			cnt_r == $past(cnt_r) + 6'h01;
	endproperty
	a_ignore: assert property (p_ignore) else $error("start accepted while busy");
	property p_alt;
		@(posedge clock) disable iff (rst) (start && channel_count_select) |=> pair_sel != $past(pair_sel);
	endproperty
	a_alt: assert property (p_alt) else $error("pair did not alternate");
	property p_fixed;
		@(posedge clock) disable iff (rst) (start && !channel_count_select) |=> pair_sel == $past(channel_pair_select);
	endproperty
	a_fixed: assert property (p_fixed) else $error("pair not host chosen");
	property p_oe;
		@(posedge clock) disable iff (rst) cs_n |=> !sdata_a_oe && !sdata_b_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("output driven while deselected");
	property p_hold;
		@(posedge clock) disable iff (rst) start |=> hold;
	endproperty
	a_hold: assert property (p_hold) else $error("hold not entered");
	property p_busy_fall;
		@(posedge clock) disable iff (rst) $fell(busy) |->
			busy_len_r == (merged_r ? 6'(`DACS_MERGED_CYCLES - `DACS_FRAME_BITS + `DACS_BUSY_DROP_BIT) :
			6'(`DACS_BUSY_DROP_BIT));
	endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("busy fall misplaced");
	c_plain: cover property (@(posedge clock) start && !output_merge_select);
	c_merged: cover property (@(posedge clock) start && output_merge_select);
	c_four: cover property (@(posedge clock) start && channel_count_select);
	c_tied: cover property (@(posedge clock) start && read_sync && !rd_d_r);
endmodule // dacs_sequencer

// ### hdl/dacs_shifter.sv
// Frame shift register that serialises one converter result.
`timescale 1ns/1ps
module dacs_shifter (
	// Clock and reset.
	input  wire logic                clock,
	input  wire logic                rst,
	// Load and shift control.
	input  wire logic                load,
	input  wire logic                shift,
	input  wire logic [1:0]          tag_bits,
	input  wire dacs_pkg::dacs_word_t result,
	// Serial bit, registered.
	output logic                     bit_out
);
	import dacs_pkg::*;

	logic [19:0] frame_r;

	// Tag bits, result MSB first, then two zeros; first bit presented on load.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			frame_r <= 20'h0_0000;
			bit_out <= 1'b0;
		end else if (load) begin
			frame_r <= {tag_bits[0], result, 2'b00, 1'b0};
			bit_out <= tag_bits[1];
		end else if (shift) begin
			frame_r <= {frame_r[18:0], 1'b0};
			bit_out <= frame_r[19];
		end
	end
endmodule // dacs_shifter

// ### tb/dacs_host.sv
// Host model: start strobe, tied read sync and the resolved serial lines.
`timescale 1ns/1ps
module dacs_host (
	// Request from the bench.
	input  wire logic go,
	// Device serial pins.
	input  wire logic sdata_a,
	input  wire logic sdata_a_oe,
	input  wire logic sdata_b,
	input  wire logic sdata_b_oe,
	// Strobes and lines.
	output logic      convert_start,
	output logic      read_sync,
	output wire       line_a,
	output wire       line_b
);
	assign convert_start = go;
	assign read_sync     = go;
	// Lines float whenever the device lets go of them.
	assign line_a = sdata_a_oe ? sdata_a : 1'bz;
	assign line_b = sdata_b_oe ? sdata_b : 1'bz;
endmodule // dacs_host

// ### tb/dacs_sequencer_tb.sv
// Self-checking testbench of the dual converter sequencer.
`timescale 1ns/1ps
module dacs_sequencer_tb;
	import dacs_pkg::*;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       go = 1'b0;
	logic       cs_n = 1'b0;
	logic       channel_count_select = 1'b0;
	logic       output_merge_select = 1'b0;
	logic       channel_pair_select = 1'b0;
	dacs_word_t result_a = 16'h0000;
	dacs_word_t result_b = 16'h0000;
	logic       convert_start, read_sync, hold, pair_sel, busy;
	logic       sdata_a, sdata_a_oe, sdata_b, sdata_b_oe;
	wire        line_a, line_b;
	int         n_fail = 0;
	int         num_checks = 0;

	dacs_sequencer dacs_sequencer_i (.clock(clock), .rst(rst), .convert_start(convert_start),
		.read_sync(read_sync), .cs_n(cs_n), .channel_count_select(channel_count_select),
		.output_merge_select(output_merge_select), .channel_pair_select(channel_pair_select),
		.result_a(result_a), .result_b(result_b), .hold(hold), .pair_sel(pair_sel),
		.sdata_a(sdata_a), .sdata_a_oe(sdata_a_oe), .sdata_b(sdata_b), .sdata_b_oe(sdata_b_oe),
		.busy(busy));
	dacs_host dacs_host_i (.go(go), .sdata_a(sdata_a), .sdata_a_oe(sdata_a_oe), .sdata_b(sdata_b),
		.sdata_b_oe(sdata_b_oe), .convert_start(convert_start), .read_sync(read_sync),
		.line_a(line_a), .line_b(line_b));

	always #50 clock = ~clock;

	// Compares one sampled bit, counting every check.
	task automatic chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One conversion: strobe, then every bit of the frame is checked, or the floating lines when cs_n is high.
	task automatic run(input logic four, input logic mrg, input logic pr, input logic csv,
		input dacs_word_t wa, input dacs_word_t wb, input logic pb);
		logic [19:0] fa;
		logic [19:0] fb;
		int          last;
		int          bend;
		fa = {pb, 1'b0, wa, 2'b00};
		fb = {pb, mrg, wb, 2'b00};
		last = mrg ? 40 : 20;
		bend = mrg ? 37 : 17;
		channel_count_select = four;
		output_merge_select = mrg;
		channel_pair_select = pr;
		cs_n = csv;
		result_a = wa;
		result_b = wb;
		go = 1'b1;
		@(negedge clock);
		go = 1'b0;
		for (int k = 1; k <= last; k++) begin
			@(negedge clock);
			go = mrg && (k == 25);
			chk(busy, k <= bend);
			chk(hold, k <= bend);
			if (k == 2)
				chk(pair_sel, four ? pb : pr);
			if (k <= 20)
				chk(line_a, csv ? 1'bz : fa[20-k]);
			if (k >= 21)
				chk(line_a, fb[40-k]);
			if (k <= 20)
				chk(line_b, (csv || mrg) ? 1'bz : fb[20-k]);
		end
		go = 1'b0;
		@(negedge clock);
	endtask

	// Main sequence.
	initial begin
		repeat (10) @(negedge clock);
		rst = 1'b0;
		chk(busy, 1'b0);
		run(1'b1, 1'b0, 1'b0, 1'b0, 16'hA5C3, 16'h5A3C, 1'b1);
		run(1'b1, 1'b1, 1'b1, 1'b0, 16'h8001, 16'h7FFE, 1'b0);
		run(1'b1, 1'b0, 1'b0, 1'b0, 16'hFFFF, 16'h0000, 1'b1);
		for (int p = 0; p < 2; p++)
			run(1'b0, 1'b0, p[0], 1'b0, 16'h1234, 16'hFEDC, 1'b0);
		run(1'b0, 1'b1, 1'b1, 1'b0, 16'hC0DE, 16'h0F0F, 1'b0);
		run(1'b0, 1'b0, 1'b1, 1'b1, 16'h3C3C, 16'hC3C3, 1'b0);
		print_verdict();
	end
endmodule // dacs_sequencer_tb
